// >>> hdl/wpc_regs.svh
// Register offsets, field layouts and timing counts for the wiper master controller.
// Assumes a 40 MHz system clock; included by bare name, definitions only.
`ifndef WPC_REGS_SVH
`define WPC_REGS_SVH

// Device side register map
`define WPC_DEV_WIPER_OFS     8'h00
`define WPC_DEV_WIPER_RESET   7'h40
`define WPC_ID_WIDTH          7
`define WPC_DIR_WRITE         1'b0
`define WPC_DIR_READ          1'b1

// Controller register map (own)
`define WPC_ADDR_W            4
`define WPC_REG_CTRL          4'h0
`define WPC_REG_WDATA         4'h1
`define WPC_REG_STATUS        4'h2
`define WPC_REG_RDATA         4'h3
`define WPC_REG_SLAVE         4'h4

// Control register fields
`define WPC_CTRL_GO_BIT       0
`define WPC_CTRL_RD_BIT       1
// Status register fields
`define WPC_ST_BUSY_BIT       0
`define WPC_ST_NACK_BIT       1
`define WPC_ST_DONE_BIT       2

// Bus timing: quarter period of the generated serial clock
`define WPC_SCL_PERIOD_NS     2600
`define WPC_CLK_PERIOD_NS     25
`define WPC_QTR_CYCLES        ((`WPC_SCL_PERIOD_NS / 4 + `WPC_CLK_PERIOD_NS - 1) / `WPC_CLK_PERIOD_NS)
`define WPC_SLAVE_RESET       7'h2A

`endif

// >>> hdl/wpc_pkg.sv
// Types shared by the wiper master controller.
// Assumes wpc_regs.svh supplies all numeric constants.
package wpc_pkg;

    typedef enum logic [3:0] {
        WPC_IDLE  = 4'h0,
        WPC_START = 4'h1,
        WPC_BITS  = 4'h2,
        WPC_ACK   = 4'h3,
        WPC_RSTRT = 4'h4,
        WPC_RBITS = 4'h5,
        WPC_MACK  = 4'h6,
        WPC_STOP  = 4'h7,
        WPC_FREE  = 4'h8
    } wpc_state_t;

    typedef enum logic [1:0] {
        WPC_PH_ID   = 2'h0,
        WPC_PH_ADDR = 2'h1,
        WPC_PH_DATA = 2'h2,
        WPC_PH_ID2  = 2'h3
    } wpc_phase_t;

endpackage

// >>> hdl/wpc_wiper_master.sv
// Two-wire bus master that writes and reads back the wiper position register
// of a 128-tap digital resistor divider slave.
// Assumes external pull-ups on both lines; the bench resolves the wires from the enables.
//
// Functional notes
// [RULE1] Slave holds seven-bit wiper tap register
// [RULE2] Higher code moves tap toward high end
// [RULE3] Slave presets wiper register to 40h
// [RULE4] Master starts transfers and drives clock
// [RULE5] Bytes shifted most significant bit first
// [RULE6] Data changes only while clock low
// [RULE7] Slave releases data line after power-up
// [RULE8] Slave ignores traffic until a START
// [RULE9] Slave ignores START during its power-up
// [RULE10] Master ends every transaction with STOP
// [RULE11] Transmitter releases, receiver acks ninth clock
// [RULE12] Slave acks id, address, write data
// [RULE13] Master acks read bytes to continue
// [RULE14] Id byte: address plus direction bit
// [RULE15] Write: START, id, address, data, STOP
// [RULE16] Slave loads wiper at last data bit
// [RULE17] Slave refuses nonzero address or id
// [RULE18] Read: id, address, restart, read id
// [RULE19] Slave sends while master keeps acking
// [RULE20] Master stops after last wanted byte
// [RULE21] Unacked read byte: slave releases line
// [RULE22] Store low seven bits, read MSB zero
`timescale 1ns/100ps
`include "wpc_regs.svh"

module wpc_wiper_master
    import wpc_pkg::*;
#(
    parameter int QTR_CYCLES = `WPC_QTR_CYCLES
)(
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic [`WPC_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   scl_in,
    output logic                        scl_out,
    output logic                        scl_oe,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe
);

    // Elaboration check; the quarter counter is sixteen bits wide
    if (QTR_CYCLES < 1 || QTR_CYCLES > 65535) begin : g_qtr_check
        $error("QTR_CYCLES out of range");
    end

    // Register decode
    // Unmapped addresses ignore writes and read back as zero
    wire wr_ctrl  = reg_wr && (reg_addr == `WPC_REG_CTRL);
    wire wr_wdata = reg_wr && (reg_addr == `WPC_REG_WDATA);
    wire wr_slave = reg_wr && (reg_addr == `WPC_REG_SLAVE);

    // Controller state; a line is pulled low only while its low flag is set
    logic [6:0]  wdata_r;
    logic [6:0]  slave_r;
    logic [6:0]  rdata_r;
    logic        nack_r;
    logic        done_r;
    logic        is_read_r;
    wpc_state_t  state_r;
    wpc_phase_t  phase_r;
    logic [15:0] qcnt_r;
    logic [1:0]  quarter_r;
    logic [2:0]  bit_r;
    logic [7:0]  shift_r;
    logic        scl_low_r;
    logic        sda_low_r;
    logic        sda_s1_r;
    logic        sda_s2_r;
    logic        scl_s1_r;
    logic        scl_s2_r;

    // A GO while busy is dropped, not queued
    wire busy = (state_r != WPC_IDLE);
    wire go   = wr_ctrl && reg_wdata[`WPC_CTRL_GO_BIT] && !busy;

    // Read mux; wiper read data has MSB zero
    wire [7:0] status_v = {5'h00, done_r, nack_r, busy};
    wire [7:0] rd_mux   = (reg_addr == `WPC_REG_CTRL)   ? {6'h00, is_read_r, busy} :
                          (reg_addr == `WPC_REG_WDATA)  ? {1'b0, wdata_r} :
                          (reg_addr == `WPC_REG_STATUS) ? status_v :
                          (reg_addr == `WPC_REG_RDATA)  ? {1'b0, rdata_r} : // [RULE22]
                          (reg_addr == `WPC_REG_SLAVE)  ? {1'b0, slave_r} : 8'h00;

    // Read data one cycle after the strobe, held otherwise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // Software-written settings; only the low seven bits reach the wiper
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdata_r <= `WPC_DEV_WIPER_RESET;
            slave_r <= `WPC_SLAVE_RESET;
        end else begin
            if (wr_wdata) begin
                wdata_r <= reg_wdata[6:0]; // [RULE22]
            end
            if (wr_slave) begin
                slave_r <= reg_wdata[6:0];
            end
        end
    end

    // Input synchronisers; first stage feeds only the second
    // Reset to the released level so that no false edge follows reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
        end else begin
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
        end
    end

    // Quarter-period tick; stalls while a slave holds the clock low
    // The stall has no limit: a slave that never lets go keeps busy high
    wire stretch = !scl_low_r && !scl_s2_r && (quarter_r == 2'd2);
    wire tick    = busy && !stretch && (qcnt_r == 16'(QTR_CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (sys_rst || !busy || tick) begin
            qcnt_r <= 16'h0000;
        end else if (!stretch) begin
            qcnt_r <= qcnt_r + 16'h0001;
        end
    end

    // Byte to send after each phase: id carries direction in bit 0
    // The address byte is fixed at zero: the slave has a single register
    wire [7:0] id_wr   = {slave_r, `WPC_DIR_WRITE}; // [RULE14]
    wire [7:0] id_rd   = {slave_r, `WPC_DIR_READ};
    wire [7:0] next_tx = (phase_r == WPC_PH_ID)   ? `WPC_DEV_WIPER_OFS :
                         (phase_r == WPC_PH_ADDR) ? (is_read_r ? id_rd : {1'b0, wdata_r}) :
                         id_rd;

    // Each bit spans four quarters: 0 clock low set data, 1 low, 2 high sample, 3 high.
    // Data bits move only in quarter 0 with the clock low, so no false START or STOP.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r   <= WPC_IDLE;
            phase_r   <= WPC_PH_ID;
            quarter_r <= 2'd0;
            bit_r     <= 3'd7;
            shift_r   <= 8'h00;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            nack_r    <= 1'b0;
            done_r    <= 1'b0;
            is_read_r <= 1'b0;
            rdata_r   <= 7'h00;
        end else if (go) begin
            state_r   <= WPC_START; // [RULE4]
            phase_r   <= WPC_PH_ID;
            quarter_r <= 2'd0;
            is_read_r <= reg_wdata[`WPC_CTRL_RD_BIT];
            nack_r    <= 1'b0;
            done_r    <= 1'b0;
            shift_r   <= id_wr;
        end else if (tick) begin
            quarter_r <= quarter_r + 2'd1;
            case (state_r)
                // START: SDA falls with SCL high, then SCL falls
                WPC_START, WPC_RSTRT: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= 1'b0;
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                            sda_low_r <= 1'b1; // [RULE6]
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            bit_r     <= 3'd7;
                            state_r   <= WPC_BITS;
                        end
                    endcase
                end
                // Master transmits, MSB first
                WPC_BITS: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= !shift_r[7]; // [RULE5]
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            shift_r   <= {shift_r[6:0], 1'b0};
                            bit_r     <= bit_r - 3'd1;
                            if (bit_r == 3'd0) begin
                                state_r <= WPC_ACK;
                            end
                        end
                    endcase
                end
                // Ninth clock: released line, slave must pull low
                WPC_ACK: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= 1'b0; // [RULE11]
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                            if (sda_s2_r) begin
                                nack_r <= 1'b1; // [RULE17]
                            end
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            bit_r     <= 3'd7;
                            shift_r   <= next_tx;
                            if (nack_r) begin
                                state_r <= WPC_STOP;
                            end else if (phase_r == WPC_PH_ID) begin
                                phase_r <= WPC_PH_ADDR; // [RULE12]
                                state_r <= WPC_BITS;
                            end else if (phase_r == WPC_PH_ADDR && is_read_r) begin
                                phase_r <= WPC_PH_ID2;
                                state_r <= WPC_RSTRT; // [RULE18]
                            end else if (phase_r == WPC_PH_ADDR) begin
                                phase_r <= WPC_PH_DATA;
                                state_r <= WPC_BITS; // [RULE15]
                            end else if (phase_r == WPC_PH_ID2) begin
                                state_r <= WPC_RBITS;
                            end else begin
                                state_r <= WPC_STOP; // [RULE16]
                            end
                        end
                    endcase
                end
                // Slave transmits; sample with the clock high
                WPC_RBITS: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= 1'b0;
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                            shift_r <= {shift_r[6:0], sda_s2_r}; // [RULE5]
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            bit_r     <= bit_r - 3'd1;
                            if (bit_r == 3'd0) begin
                                state_r <= WPC_MACK;
                            end
                        end
                    endcase
                end
                // One byte wanted: no acknowledge, slave lets go of the line
                WPC_MACK: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= 1'b0; // [RULE13]
                            rdata_r   <= shift_r[6:0]; // [RULE22]
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            state_r   <= WPC_STOP; // [RULE21]
                        end
                    endcase
                end
                // STOP: SDA rises while SCL high
                WPC_STOP: begin
                    case (quarter_r)
                        2'd0: begin
                            sda_low_r <= 1'b1;
                        end
                        2'd1: begin
                            scl_low_r <= 1'b0;
                        end
                        2'd2: begin
                            sda_low_r <= 1'b0; // [RULE10]
                        end
                        default: begin
                            state_r <= WPC_FREE; // [RULE20]
                        end
                    endcase
                end
                // Bus free time before the next START
                // Four released quarters keep the free time at one full bit
                WPC_FREE: begin
                    if (quarter_r == 2'd3) begin
                        state_r <= WPC_IDLE;
                        done_r  <= 1'b1;
                    end
                end
                default: begin
                    state_r <= WPC_IDLE;
                end
            endcase
        end
    end

    // Open-drain drive: enable only to pull low, lines released in reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe  <= scl_low_r;
            sda_oe  <= sda_low_r;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule

// >>> test/wpc_wiper_master_checker.sv
// Concurrent checks on the wiper master's bus enables and register read port.
// Assumes it is bound into wpc_wiper_master and sees only its ports.
`timescale 1ns/100ps

module wpc_wiper_master_checker #(
    parameter int QTR_CYCLES = 26
)(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_rdata,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe
);
    localparam int HOLD_MAX = 4 * QTR_CYCLES;
    logic       scl_q;
    logic       sda_q;
    logic [5:0] pulse_cnt;
    logic [5:0] pulse_nxt;
    // Line events on the enables; START and STOP need the clock released a full cycle
    wire start_ev = !scl_oe && !scl_q && sda_oe && !sda_q;
    wire stop_ev  = !scl_oe && !scl_q && !sda_oe && sda_q;
    assign pulse_nxt = start_ev ? 6'h00 : pulse_cnt + {5'h00, scl_q && !scl_oe};
    // Clock pulses since the last START, the STOP pulse included
    always_ff @(posedge mclk) begin
        scl_q     <= sys_rst ? 1'b0 : scl_oe;
        sda_q     <= sys_rst ? 1'b0 : sda_oe;
        pulse_cnt <= sys_rst ? 6'h00 : pulse_nxt;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_start;
        start_ev;
    endsequence
    sequence s_stop;
        stop_ev;
    endsequence

    property p_rst_idle;
        $fell(sys_rst) |-> !scl_oe && !sda_oe && reg_rdata == 8'h00;
    endproperty
    property p_open_drain;
        scl_out == 1'b0 && sda_out == 1'b0;
    endproperty
    property p_scl_high;
        $fell(scl_oe) |-> !scl_oe [*4];
    endproperty
    property p_scl_low;
        $rose(scl_oe) |-> scl_oe [*3];
    endproperty
    property p_sda_setup;
        $fell(scl_oe) |-> $stable(sda_oe) [*2];
    endproperty
    property p_start_hold;
        s_start |-> ##[1:HOLD_MAX] scl_oe;
    endproperty
    property p_stop_free;
        s_stop |-> (!scl_oe && !sda_oe) [*8];
    endproperty
    property p_pulse_count;
        s_stop |-> pulse_cnt inside {6'h0A, 6'h13, 6'h1C};
    endproperty

    a_rst_idle: assert property (p_rst_idle)
        else $error("bus lines not released after reset");
    a_open_drain: assert property (p_open_drain)
        else $error("line driven high");
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too short");
    a_sda_setup: assert property (p_sda_setup)
        else $error("data moved while clock high");
    a_start_hold: assert property (p_start_hold)
        else $error("no clock after start");
    a_stop_free: assert property (p_stop_free)
        else $error("bus not free after stop");
    a_pulse_count: assert property (p_pulse_count)
        else $error("wrong clock count before stop");
endmodule

bind wpc_wiper_master wpc_wiper_master_checker #(.QTR_CYCLES(QTR_CYCLES)) i_chk (
    .mclk(mclk), .sys_rst(sys_rst), .reg_rdata(reg_rdata), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// >>> test/wpc_pot_model.sv
// Behavioural two-wire slave holding a seven-bit wiper position.
// Assumes resolved pull-up wires; pwr_busy marks the power-up window.
`timescale 1ns/100ps

module wpc_pot_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary address, matches controller default
)(
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       pwr_busy,
    output logic            sda_oe,
    output logic [6:0]      wiper  // Tap index, rises toward the high end
);
    logic [7:0] b;
    logic       m;
    int         i;
    event       go;
    // Power-up preset, data line as input
    initial begin
        wiper = 7'h40;
        sda_oe = 1'b0;
    end
    // A START restarts the transfer, ignored while powering up
    always @(negedge sda) begin
        if (scl === 1'b1 && !pwr_busy) begin
            disable xfer;
            // Let the cut transfer return to its wait before the new one is signalled
            #1 -> go;
        end
    end
    // A STOP returns to standby
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            disable xfer;
            sda_oe <= 1'b0;
        end
    end
    // Slave changes the line only after a falling clock edge
    always @(go) begin : xfer
        for (i = 0; i < 8; i++) begin
            @(posedge scl);
            b = {b[6:0], sda};
        end
        @(negedge scl);
        if (b[7:1] == DEV_ADDR) begin
            sda_oe <= 1'b1;
            @(negedge scl);
            if (b[0]) begin
                m = 1'b0;
                while (!m) begin
                    b = {1'b0, wiper};
                    for (i = 7; i >= 0; i--) begin
                        sda_oe <= !b[i];
                        @(negedge scl);
                    end
                    sda_oe <= 1'b0;
                    @(posedge scl);
                    m = sda;
                    @(negedge scl);
                end
            end else begin
                sda_oe <= 1'b0;
                for (i = 0; i < 16; i++) begin
                    @(posedge scl);
                    b = {b[6:0], sda};
                    if (i % 8 == 7) begin
                        @(negedge scl);
                        if (i == 7 && b != 8'h00) disable xfer;
                        if (i == 15) wiper = b[6:0];
                        sda_oe <= 1'b1;
                        @(negedge scl);
                        sda_oe <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// >>> test/wpc_wiper_master_tb.sv
// Self-checking bench: register port tasks, pull-up wires and a wiper slave model.
// Assumes the controller's default register map; QTR_CYCLES is cut to 4 for speed.
`timescale 1ns/100ps
`include "wpc_regs.svh"

module wpc_wiper_master_tb;
    logic       mclk;
    logic       sys_rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       scl_out;
    logic       scl_oe;
    logic       sda_out;
    logic       sda_oe;
    logic       m_sda_oe;
    logic [6:0] wiper;
    logic [7:0] rv;
    int         mismatches;
    int         n_compared;
    // Pull-ups: a line is low only while some party enables its driver
    wire scl = scl_oe ? scl_out : 1'b1;
    wire sda = (sda_oe ? sda_out : 1'b1) & !m_sda_oe;

    wpc_wiper_master #(.QTR_CYCLES(4)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    wpc_pot_model i_dev (.scl(scl), .sda(sda), .pwr_busy(sys_rst), .sda_oe(m_sda_oe),
        .wiper(wiper));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write strobe; an idle edge follows so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // Read data stand from the cycle after the strobe and are held until the next strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    // Start a transfer and poll busy under a bound
    task automatic xfer(input logic rd_dir);
        int k;
        wr(`WPC_REG_CTRL, {6'h00, rd_dir, 1'b1});
        rv = 8'h01;
        for (k = 0; k < 2000 && rv[0] !== 1'b0; k++)
            rd(`WPC_REG_STATUS, rv);
        if (rv[0] !== 1'b0) begin
            mismatches++;
            results();
        end
    endtask

    task automatic t_reset;
        logic [3:0] a [4] = '{`WPC_REG_WDATA, `WPC_REG_SLAVE, `WPC_REG_STATUS, 4'hF};
        logic [7:0] e [4] = '{8'h40, 8'h2A, 8'h00, 8'h00};
        wr(4'hF, 8'hFF);
        foreach (a[j]) begin
            rd(a[j], rv);
            check("reset reg", rv, e[j]);
        end
        check("wiper preset", {1'b0, wiper}, 8'h40);
        $display("test reset done");
    endtask
    task automatic t_write_read;
        logic [7:0] v [4] = '{8'h00, 8'h7F, 8'hC5, 8'h40};
        foreach (v[j]) begin
            wr(`WPC_REG_WDATA, v[j]);
            xfer(1'b0);
            check("wiper", {1'b0, wiper}, {1'b0, v[j][6:0]});
            rd(`WPC_REG_STATUS, rv);
            check("write status", rv, 8'h04);
            xfer(1'b1);
            rd(`WPC_REG_RDATA, rv);
            check("read data", rv, {1'b0, v[j][6:0]});
            rd(`WPC_REG_STATUS, rv);
            check("read status", rv, 8'h04);
        end
        $display("test write_read done");
    endtask
    // Wrong slave address: refused, wiper untouched
    task automatic t_bad_id;
        wr(`WPC_REG_SLAVE, 8'h15);
        wr(`WPC_REG_WDATA, 8'h11);
        xfer(1'b0);
        rd(`WPC_REG_STATUS, rv);
        check("nack status", rv, 8'h06);
        check("wiper kept", {1'b0, wiper}, 8'h40);
        wr(`WPC_REG_SLAVE, 8'h2A);
        $display("test bad_id done");
    endtask
    // GO while busy is refused; control register reads back direction and busy
    task automatic t_busy_go;
        wr(`WPC_REG_WDATA, 8'h2B);
        wr(`WPC_REG_CTRL, 8'h01);
        xfer(1'b1);
        rd(`WPC_REG_CTRL, rv);
        check("ctrl after write", rv, 8'h00);
        check("wiper busy go", {1'b0, wiper}, 8'h2B);
        xfer(1'b1);
        rd(`WPC_REG_CTRL, rv);
        check("ctrl after read", rv, 8'h02);
        rd(`WPC_REG_RDATA, rv);
        check("read busy go", rv, 8'h2B);
        $display("test busy_go done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        mismatches = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_write_read();
        t_bad_id();
        t_busy_go();
        results();
    end
endmodule
